// ---- src/fpg_pkg.sv ----
package fpg_pkg;
    // ------------------------------------------------------------
    // geometry of user flash
    // ------------------------------------------------------------
    localparam int ADDR_W = 14;
    localparam logic [13:0] FLASH_TOP = 14'h3FFF;
    localparam logic [13:0] STORAGE_WORDS = 14'h0080;
    localparam logic [13:0] STORAGE_BASE = 14'h3F80;
    // boot block size per size code: 512 words shifted by code (plain default)
    localparam logic [13:0] BOOT_UNIT = 14'h0200;

    // ------------------------------------------------------------
    // register map (byte offsets)
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CONFIG = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;
    localparam logic [7:0] OFS_MASK = 8'h08;
    localparam logic [7:0] OFS_BOOT_END = 8'h0C;

    // config fields as read back
    localparam int CFG_BOOT_DIS_N = 0;
    localparam int CFG_SAF_DIS_N = 1;
    localparam int CFG_SIZE_LO = 2;
    localparam int CFG_WP_APP = 5;
    localparam int CFG_WP_BOOT = 6;
    localparam int CFG_WP_SAF = 7;

    // status / mask bits
    localparam int ST_WRITE_ERROR_FLAG = 0;
    localparam int ST_EXECV = 1;
    localparam int ST_W = 2;

    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

    typedef enum {REG_APP, REG_BOOT, REG_SAF} fpg_region_e;
endpackage : fpg_pkg

// ---- src/fpg_region_if.sv ----
`timescale 1ns/1ps
`default_nettype none
// partition settings shared between the guard and the decoder
interface fpg_region_if;
    logic boot_en;
    logic saf_en;
    logic [2:0] boot_size;
    logic [13:0] boot_end;
    logic [13:0] fetch_addr;
    logic [13:0] write_addr;
    logic fetch_saf;
    logic fetch_boot;
    logic write_saf;
    logic write_boot;
    modport guard (output boot_en, saf_en, boot_size, fetch_addr, write_addr,
                   input boot_end, fetch_saf, fetch_boot, write_saf, write_boot);
    modport decode (input boot_en, saf_en, boot_size, fetch_addr, write_addr,
                    output boot_end, fetch_saf, fetch_boot, write_saf, write_boot);
endinterface : fpg_region_if
`default_nettype wire

// ---- src/fpg_region_decode.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpg_region_decode (
    fpg_region_if.decode rif
);
    // ------------------------------------------------------------
    // address classification
    // ------------------------------------------------------------
    function automatic logic in_saf(input logic en, input logic [13:0] a);
        in_saf = en && (a >= fpg_pkg::STORAGE_BASE);
    endfunction : in_saf

    function automatic logic in_boot(input logic en, input logic [13:0] lim,
                                     input logic [13:0] a);
        in_boot = en && (a < lim);
    endfunction : in_boot

    // boot range grows from address zero; size code doubles it
    always_comb begin
        rif.boot_end = 14'((fpg_pkg::BOOT_UNIT << rif.boot_size) - 14'h0001) + 14'h0001;
        if (rif.boot_size == 3'h5) begin
            rif.boot_end = fpg_pkg::STORAGE_BASE; // wider codes saturate below storage
        end else if (rif.boot_size > 3'h5) begin
            rif.boot_end = fpg_pkg::STORAGE_BASE;
        end
    end

    // storage area is the top 128 words
    assign rif.fetch_saf = in_saf(rif.saf_en, rif.fetch_addr);
    assign rif.write_saf = in_saf(rif.saf_en, rif.write_addr);
    assign rif.fetch_boot = in_boot(rif.boot_en, rif.boot_end, rif.fetch_addr);
    assign rif.write_boot = in_boot(rif.boot_en, rif.boot_end, rif.write_addr);
endmodule : fpg_region_decode
`default_nettype wire

// ---- src/fpg_guard.sv ----
// Design decisions made here: the register addresses and the AHB-Lite slave port.
`timescale 1ns/1ps
`default_nettype none
module fpg_guard (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    // configuration fuses, static after power-up
    input wire logic BOOT_REGION_DISABLE_N,
    input wire logic STORAGE_AREA_DISABLE_N,
    input wire logic [2:0] BOOT_REGION_SIZE,
    input wire logic APP_REGION_WRITE_PROTECT,
    input wire logic BOOT_REGION_WRITE_PROTECT,
    input wire logic CONFIG_REGION_WRITE_PROTECT,
    // cpu fetch path
    input wire logic FETCH_EXEC,
    input wire logic [13:0] FETCH_ADDR,
    output logic EXEC_VIOLATION_RESET,
    // memory write controller request / grant
    input wire logic WRITE_REQ,
    input wire logic [13:0] WRITE_ADDR,
    output logic WRITE_GRANT,
    output logic WRITE_DONE,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    output logic IRQ
);
    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef enum {FPG_SYNC, FPG_SETTLE, FPG_LATCH, FPG_RUN} fpg_phase_e;

    typedef struct packed {
        fpg_phase_e phase;
        logic [7:0] cfg;          // fuse snapshot taken after reset
        logic [1:0] status;       // sticky events
        logic [1:0] mask;
        logic exec_flag;          // set by software-free reset path, cleared by violation
        logic viol_rst;
        logic grant;
        logic done;
        logic served;             // request answered, waiting for it to drop
        logic wr_pend;
        logic [7:0] ap_addr;
        logic [31:0] rdata;
    } fpg_state_s;

    fpg_state_s cur;
    fpg_state_s next_cur;

    fpg_region_if rif();

    fpg_region_decode u_decode (
        .rif(rif)
    );

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [13:0] fetch_addr_s1, fetch_addr_s2;
    logic [13:0] write_addr_s1, write_addr_s2;
    logic [7:0] fuse_s1, fuse_s2;
    logic fetch_s1, fetch_s2, wreq_s1, wreq_s2;

    // fetch and write come from other logic but through pins, so two flops each
    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            fetch_addr_s1 <= 14'h0000;
            fetch_addr_s2 <= 14'h0000;
            write_addr_s1 <= 14'h0000;
            write_addr_s2 <= 14'h0000;
            fuse_s1 <= 8'hFF;
            fuse_s2 <= 8'hFF;
            fetch_s1 <= 1'b0;
            fetch_s2 <= 1'b0;
            wreq_s1 <= 1'b0;
            wreq_s2 <= 1'b0;
        end else begin
            fetch_addr_s1 <= FETCH_ADDR;
            fetch_addr_s2 <= fetch_addr_s1;
            write_addr_s1 <= WRITE_ADDR;
            write_addr_s2 <= write_addr_s1;
            fuse_s1 <= {CONFIG_REGION_WRITE_PROTECT, BOOT_REGION_WRITE_PROTECT,
                        APP_REGION_WRITE_PROTECT, BOOT_REGION_SIZE,
                        STORAGE_AREA_DISABLE_N, BOOT_REGION_DISABLE_N};
            fuse_s2 <= fuse_s1;
            fetch_s1 <= FETCH_EXEC;
            fetch_s2 <= fetch_s1;
            wreq_s1 <= WRITE_REQ;
            wreq_s2 <= wreq_s1;
        end
    end

    // ------------------------------------------------------------
    // partition decode hookup
    // ------------------------------------------------------------
    // disable fuses act when high: a 1 keeps the region folded into the app, a 0 enables it
    assign rif.boot_en = ~cur.cfg[fpg_pkg::CFG_BOOT_DIS_N];
    assign rif.saf_en = ~cur.cfg[fpg_pkg::CFG_SAF_DIS_N];
    assign rif.boot_size = cur.cfg[fpg_pkg::CFG_SIZE_LO +: 3];
    assign rif.fetch_addr = fetch_addr_s2;
    assign rif.write_addr = write_addr_s2;

    logic write_protected;
    logic fetch_bad;
    logic ahb_take;
    logic [fpg_pkg::ST_W-1:0] set_ev;

    // pick the write-protect fuse of the region the write lands in
    always_comb begin
        if (rif.write_saf) begin
            write_protected = cur.cfg[fpg_pkg::CFG_WP_SAF];
        end else if (rif.write_boot) begin
            write_protected = cur.cfg[fpg_pkg::CFG_WP_BOOT];
        end else begin
            write_protected = cur.cfg[fpg_pkg::CFG_WP_APP];
        end
    end

    // storage area is data only; a fetch there is a violation
    assign fetch_bad = fetch_s2 && rif.fetch_saf;

    assign ahb_take = HSEL && HREADY && (HTRANS == fpg_pkg::HTRANS_NONSEQ);

    // ------------------------------------------------------------
    // next-state logic
    // ------------------------------------------------------------
    always_comb begin
        set_ev = 2'h0;
        next_cur = cur;
        next_cur.grant = 1'b0;
        next_cur.done = 1'b0;
        next_cur.viol_rst = 1'b0;
        case (cur.phase)
            FPG_SYNC: begin
                next_cur.phase = FPG_SETTLE;
            end
            FPG_SETTLE: begin
                next_cur.phase = FPG_LATCH;
            end
            FPG_LATCH: begin
                // both sync stages now hold the fuses, no longer their reset value
                next_cur.cfg = fuse_s2;
                next_cur.phase = FPG_RUN;
            end
            FPG_RUN: begin
                // request is seen late through the sync, so it must drop before re-arming
                if (!wreq_s2) begin
                    next_cur.served = 1'b0;
                end
                // a blocked write leaves flash untouched: done pulses without grant and the error flag rises
                if (wreq_s2 && !cur.served) begin
                    next_cur.done = 1'b1;
                    next_cur.served = 1'b1;
                    if (write_protected) begin
                        set_ev[fpg_pkg::ST_WRITE_ERROR_FLAG] = 1'b1;
                    end else begin
                        next_cur.grant = 1'b1;
                    end
                end
                if (fetch_bad) begin
                    next_cur.viol_rst = 1'b1;
                    next_cur.exec_flag = 1'b0;
                    set_ev[fpg_pkg::ST_EXECV] = 1'b1;
                end
            end
            default: begin
                next_cur.phase = FPG_SYNC;
            end
        endcase

        // read data caught at the address phase so it stands through the data phase
        if (ahb_take && !HWRITE) begin
            case (HADDR[7:0])
                fpg_pkg::OFS_CONFIG: next_cur.rdata = {24'h000000, cur.cfg};
                fpg_pkg::OFS_STATUS: next_cur.rdata = {30'h00000000, cur.status};
                fpg_pkg::OFS_MASK: next_cur.rdata = {30'h00000000, cur.mask};
                fpg_pkg::OFS_BOOT_END: next_cur.rdata = {18'h00000, rif.boot_end};
                default: next_cur.rdata = 32'h00000000;
            endcase
            if (HADDR[7:0] == fpg_pkg::OFS_STATUS) begin
                next_cur.status = 2'h0;
            end
        end
        // an event in the clearing cycle still sets its bit
        next_cur.status = next_cur.status | set_ev;
        if (cur.wr_pend && cur.ap_addr == fpg_pkg::OFS_MASK) begin
            next_cur.mask = HWDATA[1:0];
        end
        next_cur.wr_pend = ahb_take && HWRITE;
        if (ahb_take) begin
            next_cur.ap_addr = HADDR[7:0];
        end
    end

    always_ff @(posedge SYS_CLK or negedge RST_N) begin
        if (!RST_N) begin
            cur <= '{phase: FPG_SYNC, cfg: 8'hFF, status: 2'h0, mask: 2'h0,
                     exec_flag: 1'b1, viol_rst: 1'b0, grant: 1'b0, done: 1'b0,
                     served: 1'b0, wr_pend: 1'b0, ap_addr: 8'h00, rdata: 32'h00000000};
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign EXEC_VIOLATION_RESET = cur.viol_rst;
    assign WRITE_GRANT = cur.grant;
    assign WRITE_DONE = cur.done;
    assign HRDATA = cur.rdata;
    assign HREADYOUT = 1'b1;   // zero wait states
    assign HRESP = 1'b0;
    assign IRQ = |(cur.status & cur.mask);
endmodule : fpg_guard
`default_nettype wire

// ---- testbench/fpg_guard_assertions.sv ----
`timescale 1ns/1ps
`default_nettype none
// ----------
// write grant and fetch checks
// ----------
module fpg_guard_assertions (
    input wire logic SYS_CLK,
    input wire logic RST_N,
    input wire logic BOOT_REGION_DISABLE_N,
    input wire logic STORAGE_AREA_DISABLE_N,
    input wire logic [2:0] BOOT_REGION_SIZE,
    input wire logic APP_REGION_WRITE_PROTECT,
    input wire logic BOOT_REGION_WRITE_PROTECT,
    input wire logic CONFIG_REGION_WRITE_PROTECT,
    input wire logic FETCH_EXEC,
    input wire logic [13:0] FETCH_ADDR,
    input wire logic EXEC_VIOLATION_RESET,
    input wire logic WRITE_REQ,
    input wire logic [13:0] WRITE_ADDR,
    input wire logic WRITE_GRANT,
    input wire logic WRITE_DONE
);
    logic [13:0] boot_lim;
    logic wr_prot;
    logic bad_fetch;
    // fuses only change under reset, so a live decode is enough
    assign boot_lim = (BOOT_REGION_SIZE > 3'h4) ? fpg_pkg::STORAGE_BASE
                      : (fpg_pkg::BOOT_UNIT << BOOT_REGION_SIZE);
    assign wr_prot = (!STORAGE_AREA_DISABLE_N && WRITE_ADDR >= fpg_pkg::STORAGE_BASE)
        ? CONFIG_REGION_WRITE_PROTECT : (!BOOT_REGION_DISABLE_N && WRITE_ADDR < boot_lim)
        ? BOOT_REGION_WRITE_PROTECT : APP_REGION_WRITE_PROTECT;
    assign bad_fetch = FETCH_EXEC && !STORAGE_AREA_DISABLE_N
                       && FETCH_ADDR >= fpg_pkg::STORAGE_BASE;
    default clocking cb @(posedge SYS_CLK); endclocking
    default disable iff (!RST_N);
    property p_done_time; $rose(WRITE_REQ) |-> ##[2:4] WRITE_DONE; endproperty
    a_done_time: assert property (p_done_time) else $error("late done");
    property p_done_pulse; WRITE_DONE |=> !WRITE_DONE; endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("long done");
    property p_grant_prot; WRITE_GRANT |-> !wr_prot; endproperty
    a_grant_prot: assert property (p_grant_prot) else $error("protected grant");
    property p_grant_ok; $rose(WRITE_REQ) && !wr_prot |-> ##[1:4] WRITE_GRANT; endproperty
    a_grant_ok: assert property (p_grant_ok) else $error("no grant");
    property p_refuse; $rose(WRITE_REQ) && wr_prot |-> !WRITE_GRANT [*5]; endproperty
    a_refuse: assert property (p_refuse) else $error("refusal broken");
    property p_viol; $rose(FETCH_EXEC) && bad_fetch |-> ##[1:3] EXEC_VIOLATION_RESET; endproperty
    a_viol: assert property (p_viol) else $error("no violation");
    property p_viol_cause; EXEC_VIOLATION_RESET |-> $past(bad_fetch, 3); endproperty
    a_viol_cause: assert property (p_viol_cause) else $error("spurious violation");
    property p_viol_pulse; EXEC_VIOLATION_RESET |=> !EXEC_VIOLATION_RESET; endproperty
    a_viol_pulse: assert property (p_viol_pulse) else $error("long violation");
    // main scenarios reached
    c_refused: cover property ($rose(WRITE_REQ) && wr_prot);
    c_granted: cover property (WRITE_GRANT);
    c_violation: cover property (EXEC_VIOLATION_RESET);
endmodule : fpg_guard_assertions
bind fpg_guard fpg_guard_assertions u_fpg_guard_assertions (.SYS_CLK, .RST_N,
    .BOOT_REGION_DISABLE_N, .STORAGE_AREA_DISABLE_N, .BOOT_REGION_SIZE,
    .APP_REGION_WRITE_PROTECT, .BOOT_REGION_WRITE_PROTECT, .CONFIG_REGION_WRITE_PROTECT,
    .FETCH_EXEC, .FETCH_ADDR, .EXEC_VIOLATION_RESET, .WRITE_REQ, .WRITE_ADDR,
    .WRITE_GRANT, .WRITE_DONE);
`default_nettype wire

// ---- testbench/fpg_host_model.sv ----
`timescale 1ns/1ps
`default_nettype none
module fpg_host_model (
    input wire logic clk,
    input wire logic viol,
    input wire logic grant,
    input wire logic done,
    output logic fetch_exec,
    output logic [13:0] fetch_addr,
    output logic write_req,
    output logic [13:0] write_addr
);
    // idle at time zero
    initial {fetch_exec, fetch_addr, write_req, write_addr} = '0;
    // request held until done, then three idle cycles before the next
    task automatic nvm_write(input logic [13:0] a, output logic g);
        g = 1'b0;
        @(posedge clk);
        write_req <= 1'b1;
        write_addr <= a;
        do begin
            @(posedge clk);
            g |= (grant === 1'b1);
        end while (done !== 1'b1);
        write_req <= 1'b0;
        write_addr <= ~a; // inverted so a stale address never passes
        repeat (3) @(posedge clk);
    endtask : nvm_write
    // one executed instruction, then watch for the violation pulse
    task automatic fetch(input logic [13:0] a, output logic v);
        v = 1'b0;
        @(posedge clk);
        fetch_exec <= 1'b1;
        fetch_addr <= a;
        @(posedge clk);
        fetch_exec <= 1'b0;
        fetch_addr <= ~a;
        repeat (4) begin
            @(posedge clk);
            v |= (viol === 1'b1);
        end
    endtask : fetch
endmodule : fpg_host_model
`default_nettype wire

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic SYS_CLK, RST_N, BOOT_REGION_DISABLE_N, STORAGE_AREA_DISABLE_N, g, HWRITE, HREADYOUT;
    logic APP_REGION_WRITE_PROTECT, BOOT_REGION_WRITE_PROTECT, CONFIG_REGION_WRITE_PROTECT;
    logic FETCH_EXEC, EXEC_VIOLATION_RESET, WRITE_REQ, WRITE_GRANT, WRITE_DONE, HRESP, IRQ;
    logic [2:0] BOOT_REGION_SIZE;
    logic [13:0] FETCH_ADDR, WRITE_ADDR, lim;
    logic [31:0] HADDR, HWDATA, HRDATA, r;
    logic [1:0] HTRANS;
    int fails = 0, n_compared = 0, cyc = 0;
    fpg_guard u_fpg_guard (.SYS_CLK, .RST_N, .BOOT_REGION_DISABLE_N, .STORAGE_AREA_DISABLE_N,
        .BOOT_REGION_SIZE, .APP_REGION_WRITE_PROTECT, .BOOT_REGION_WRITE_PROTECT,
        .CONFIG_REGION_WRITE_PROTECT, .FETCH_EXEC, .FETCH_ADDR, .EXEC_VIOLATION_RESET,
        .WRITE_REQ, .WRITE_ADDR, .WRITE_GRANT, .WRITE_DONE, .HSEL(1'b1), .HADDR, .HTRANS,
        .HWRITE, .HSIZE(3'h2), .HWDATA, .HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .IRQ);
    fpg_host_model u_fpg_host_model (.clk(SYS_CLK), .viol(EXEC_VIOLATION_RESET),
        .grant(WRITE_GRANT), .done(WRITE_DONE), .fetch_exec(FETCH_EXEC),
        .fetch_addr(FETCH_ADDR), .write_req(WRITE_REQ), .write_addr(WRITE_ADDR));
    // 200 MHz system clock
    initial begin
        SYS_CLK = 1'b0;
        forever #2.5 SYS_CLK = ~SYS_CLK;
    end
    // hang guard, far above the few hundred cycles needed
    always @(posedge SYS_CLK) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fails++;
            end_sim();
        end
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask : chk
    // single word transfer; hangs are cut by the guard above
    task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge SYS_CLK);
        HTRANS <= fpg_pkg::HTRANS_NONSEQ;
        HADDR <= {24'h000000, a};
        HWRITE <= w;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= d;
        do @(posedge SYS_CLK); while (HREADYOUT !== 1'b1);
        r = HRDATA;
    endtask : ahb
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        ahb(1'b0, a, 32'h00000000);
        chk(r, e);
    endtask : rchk
    task automatic wchk(input logic [13:0] a, input logic e);
        u_fpg_host_model.nvm_write(a, g);
        chk({31'h0, g}, {31'h0, e});
    endtask : wchk
    task automatic fchk(input logic [13:0] a, input logic e);
        u_fpg_host_model.fetch(a, g);
        chk({31'h0, g}, {31'h0, e});
    endtask : fchk
    task automatic ichk(input logic e);
        repeat (2) @(posedge SYS_CLK);
        chk({31'h0, IRQ}, {31'h0, e});
    endtask : ichk
    // fuses only take effect through a reset
    task automatic boot(input logic [2:0] code, input logic [4:0] f);
        {BOOT_REGION_DISABLE_N, STORAGE_AREA_DISABLE_N, APP_REGION_WRITE_PROTECT,
            BOOT_REGION_WRITE_PROTECT, CONFIG_REGION_WRITE_PROTECT} <= f;
        BOOT_REGION_SIZE <= code;
        RST_N <= 1'b0;
        repeat (8) @(posedge SYS_CLK);
        RST_N <= 1'b1;
        repeat (4) @(posedge SYS_CLK);
    endtask : boot
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask : end_sim
    // main sequence
    initial begin
        {RST_N, HTRANS, HADDR, HWRITE, HWDATA, BOOT_REGION_DISABLE_N, STORAGE_AREA_DISABLE_N,
            APP_REGION_WRITE_PROTECT, BOOT_REGION_WRITE_PROTECT, CONFIG_REGION_WRITE_PROTECT,
            BOOT_REGION_SIZE} = '0;
        boot(3'h2, 5'b11000);
        wchk(14'h0000, 1'b1);
        wchk(14'h3FFF, 1'b1);
        fchk(14'h3FFF, 1'b0);
        rchk(fpg_pkg::OFS_CONFIG, 32'h0000000B);
        rchk(8'h10, 32'h00000000);
        // each size code: boot end boundary, last boot word protected, first word past it writable (storage for codes 5 to 7)
        for (int c = 0; c < 8; c++) begin
            lim = (c > 4) ? fpg_pkg::STORAGE_BASE : fpg_pkg::BOOT_UNIT << c;
            boot(c[2:0], 5'b00010);
            wchk(lim - 14'h0001, 1'b0);
            wchk(lim, 1'b1);
            rchk(fpg_pkg::OFS_STATUS, 32'h00000001);
            rchk(fpg_pkg::OFS_STATUS, 32'h00000000);
        end
        fchk(fpg_pkg::STORAGE_BASE, 1'b1);
        fchk(14'h3F7F, 1'b0);
        fchk(14'h0000, 1'b0);
        rchk(fpg_pkg::OFS_STATUS, 32'h00000002);
        // error held masked, then raised, then cleared by the status read
        wchk(14'h0000, 1'b0);
        ichk(1'b0);
        ahb(1'b1, fpg_pkg::OFS_MASK, 32'h00000003);
        ichk(1'b1);
        rchk(fpg_pkg::OFS_STATUS, 32'h00000001);
        ichk(1'b0);
        boot(3'h0, 5'b10101);
        wchk(14'h1000, 1'b0);
        wchk(fpg_pkg::STORAGE_BASE, 1'b0);
        end_sim();
    end
endmodule : tb
`default_nettype wire
